// ===== design/crr_cfg.svh
// Constants of the card register readout block.
// Included by the top module; definitions only.
`ifndef CRR_CFG_SVH
`define CRR_CFG_SVH
`define CRR_PKG_BGA      2'h1
`define CRR_STRUCTURE    2'h3
`define CRR_SPEC_VER     4'h4
`define CRR_ACC_FIXED    8'h27
`define CRR_ACC_CLOCKS   8'h01
`define CRR_SPEED        8'h32
`define CRR_CMD_CLASSES  12'h0f5
`define CRR_BLK_LEN      4'h9
`define CRR_DEV_SIZE     12'hfff
`define CRR_CURRENT      3'h7
`define CRR_SIZE_MULT    3'h7
`define CRR_ERASE_SIZE   5'h1f
`define CRR_ERASE_MULT   5'h1f
`define CRR_PROT_SIZE    5'h0f
`define CRR_R2W          3'h2
`define CRR_PROG_RESET   8'h40
`define CRR_PROG_COPY    6
`define CRR_PROG_PERM    5
`define CRR_CRC_POLY     7'h09
`define CRR_MODE_SECTOR  2'h2
`define CRR_MODE_BYTE    2'h0
`define CRR_VOLT_LOW     1'b1
`define CRR_VOLT_HIGH    9'h1ff
`define CRR_TWO_GB       64'h0000_0000_8000_0000
`define CRR_SECTOR_PAD   9'h000
`define CRR_CLOCK_UNIT   16'h0064
`define CRR_POWERUP_CYC  12'h3e8
`endif

// ===== design/crr_pkg.sv
// Types of the card register readout block.
// Assumes nothing beyond the constants header.
package crr_pkg;
  typedef enum logic [1:0] {CRR_SEL_OPCOND, CRR_SEL_IDENT, CRR_SEL_SPEC} crr_sel_type;
  typedef enum logic {CRR_T_IDLE, CRR_T_RUN} crr_tstate_type;
  typedef struct packed {
    logic [7:0]  maker;
    logic [5:0]  rsv;
    logic [1:0]  package_type;
    logic [7:0]  application_code;
    logic [47:0] product_name;
    logic [7:0]  product_revision;
    logic [31:0] serial_number;
    logic [7:0]  manufacture_date;
    logic [6:0]  checksum;
    logic        end_bit;
  } crr_ident_type;
  typedef struct packed {
    logic [1:0]  structure;
    logic [3:0]  spec_version;
    logic [1:0]  rsv0;
    logic [7:0]  access_time_fixed;
    logic [7:0]  access_time_clocks;
    logic [7:0]  transfer_speed;
    logic [11:0] command_classes;
    logic [3:0]  read_block_length;
    logic        partial_read_permit;
    logic        write_misalign;
    logic        read_misalign;
    logic        driver_stage_present;
    logic [1:0]  rsv1;
    logic [11:0] device_size;
    logic [11:0] currents;
    logic [2:0]  size_mult;
    logic [4:0]  erase_group_size;
    logic [4:0]  erase_group_multiplier;
    logic [4:0]  protect_group_size;
    logic        protect_group_enable;
    logic [1:0]  default_ecc;
    logic [2:0]  write_speed_factor;
    logic [3:0]  write_block_length;
    logic        partial_write_permit;
    logic [3:0]  rsv2;
    logic        content_prot;
    logic [7:0]  prog_bits;
    logic [6:0]  checksum;
    logic        end_bit;
  } crr_spec_type;
  typedef struct packed {
    logic         valid;
    logic [127:0] data;
  } crr_rd_type;
  typedef struct packed {
    logic        valid;
    logic [40:0] byte_addr;
  } crr_addr_type;
endpackage

// ===== design/crr_card_register_readout.sv
// Identity, specific-data and operating-conditions readout with address scaling.
// Assumes the command logic on clk_i issues one-cycle read, write and address pulses;
// bus_clk_i is the host bus clock pin, sampled here.
// Function
// - Above 2 GB every data address argument is a sector number
// - In sector mode one argument unit selects one 512-byte sector
// - Up to 2 GB the 32-bit argument is a byte offset
// - Access-mode field reads binary 10 for devices above 2 GB
// - A 128-bit identity register is returned as one value
// - Identity layout: maker, reserved, package, application, name, revision, serial, date
// - Identity carries CRC7 over its contents; lowest bit reads one
// - Fixed access-time field 119:112 reports 27h
// - Clock access-time field 111:104 reports 01h, units of 100 bus clocks
// - Transfer-speed field 103:96 reports 32h
// - Read block length 83:80 reports 9, 512-byte blocks
// - Partial-read permit bit 79 reads zero
// - Write block length 25:22 reports 9; partial-write permit reads zero
// - Driver-stage-present bit 76 reads zero
// - Erase group size and multiplier each report 1Fh
// - Protect group size reports 0Fh; protect group enable reads one
// - Specific data carries CRC7 at 7:1; bit 0 reads one
`timescale 1ns/1ps
`include "crr_cfg.svh"
module crr_card_register_readout #(
  parameter logic [63:0]  DEV_BYTES    = 64'h0000_0040_0000_0000,
  parameter logic [7:0]   MAKER_CODE   = 8'h5a,         // Arbitrary value
  parameter logic [7:0]   APP_CODE     = 8'ha5,         // Arbitrary value
  parameter logic [47:0]  PRODUCT_NAME = 48'h4142_4344_4546, // Arbitrary value
  parameter logic [7:0]   PRODUCT_REV  = 8'h10,         // Arbitrary value
  parameter logic [31:0]  SERIAL       = 32'h0000_0001, // Arbitrary value
  parameter logic [7:0]   MFG_DATE     = 8'h11          // Arbitrary value
) (
  input  wire  logic                 clk_i,
  input  wire  logic                 nrst_i,
  input  wire  logic                 bus_clk_i,
  input  wire  logic                 rd_req_i,
  input  wire  crr_pkg::crr_sel_type rd_sel_i,
  input  wire  logic                 wr_req_i,
  input  wire  crr_pkg::crr_sel_type wr_sel_i,
  input  wire  logic [127:0]         wr_data_i,
  input  wire  logic                 addr_req_i,
  input  wire  logic [31:0]          addr_arg_i,
  output logic                       rd_valid_o,
  output logic [127:0]               rd_data_o,
  output logic                       wr_done_o,
  output logic                       wr_refused_o,
  output logic                       addr_valid_o,
  output logic [40:0]                byte_addr_o,
  output logic                       sector_mode_o,
  output logic                       ready_o,
  output logic                       access_expired_o
);
  import crr_pkg::*;

  localparam logic SECTOR_MODE = (DEV_BYTES > `CRR_TWO_GB);

  // =====================================================
  // Checksum
  // =====================================================
  function automatic logic [6:0] crr_crc7(input logic [119:0] d);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = 119; i >= 0; i--)
    begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0} ^ (fb ? `CRR_CRC_POLY : 7'h00);
    end
    return c;
  endfunction

  // =====================================================
  // Register contents
  // =====================================================
  logic [7:0]    prog;
  logic [7:0]    next_prog;
  crr_ident_type ident_base;
  crr_spec_type  spec_base;
  logic [127:0]  ident_word;
  logic [127:0]  spec_word;
  logic [127:0]  opcond_word;

  always_comb
  begin
    ident_base                  = '0;
    ident_base.maker            = MAKER_CODE;
    ident_base.package_type     = `CRR_PKG_BGA;
    ident_base.application_code = APP_CODE;
    ident_base.product_name     = PRODUCT_NAME;
    ident_base.product_revision = PRODUCT_REV;
    ident_base.serial_number    = SERIAL;
    ident_base.manufacture_date = MFG_DATE;
    ident_base.end_bit          = 1'b1;
  end

  always_comb
  begin
    spec_base                        = '0;
    spec_base.structure              = `CRR_STRUCTURE;
    spec_base.spec_version           = `CRR_SPEC_VER;
    spec_base.access_time_fixed      = `CRR_ACC_FIXED;
    spec_base.access_time_clocks     = `CRR_ACC_CLOCKS;
    spec_base.transfer_speed         = `CRR_SPEED;
    spec_base.command_classes        = `CRR_CMD_CLASSES;
    spec_base.read_block_length      = `CRR_BLK_LEN;
    spec_base.partial_read_permit    = 1'b0;
    spec_base.driver_stage_present   = 1'b0;
    spec_base.device_size            = `CRR_DEV_SIZE;
    spec_base.currents               = {4{`CRR_CURRENT}};
    spec_base.size_mult              = `CRR_SIZE_MULT;
    spec_base.erase_group_size       = `CRR_ERASE_SIZE;
    spec_base.erase_group_multiplier = `CRR_ERASE_MULT;
    spec_base.protect_group_size     = `CRR_PROT_SIZE;
    spec_base.protect_group_enable   = 1'b1;
    spec_base.write_speed_factor     = `CRR_R2W;
    spec_base.write_block_length     = `CRR_BLK_LEN;
    spec_base.partial_write_permit   = 1'b0;
    spec_base.prog_bits              = prog;
    spec_base.end_bit                = 1'b1;
  end

  // Checksums follow the live programmable bits, so they never go stale
  assign ident_word = {ident_base[127:8], crr_crc7(ident_base[127:8]), 1'b1};
  assign spec_word  = {spec_base[127:8], crr_crc7(spec_base[127:8]), 1'b1};

  assign opcond_word = {96'h0, ready_o,
                        (sector_mode_o ? `CRR_MODE_SECTOR : `CRR_MODE_BYTE),
                        5'h00, `CRR_VOLT_HIGH, 7'h00, `CRR_VOLT_LOW, 7'h00};

  // =====================================================
  // Read and write port
  // =====================================================
  crr_rd_type rd;
  crr_rd_type next_rd;
  logic       wr_ok;
  logic       next_wr_done;
  logic       next_wr_refused;

  // Only bits 15:8 are programmable; the checksum written is ignored and recomputed
  assign wr_ok = (wr_sel_i == CRR_SEL_SPEC) && (wr_data_i[127:16] == spec_word[127:16]);

  always_comb
  begin
    next_rd.valid = rd_req_i;
    unique case (rd_sel_i)
      CRR_SEL_IDENT:  next_rd.data = ident_word;
      CRR_SEL_SPEC:   next_rd.data = spec_word;
      default:        next_rd.data = opcond_word;
    endcase
    next_prog       = prog;
    next_wr_done    = wr_req_i;
    next_wr_refused = wr_req_i && !wr_ok;
    if (wr_req_i && wr_ok)
    begin
      next_prog = wr_data_i[15:8];
      // Copy and permanent protect are one-time: once set they stay set
      next_prog[`CRR_PROG_COPY] = wr_data_i[8 + `CRR_PROG_COPY] | prog[`CRR_PROG_COPY];
      next_prog[`CRR_PROG_PERM] = wr_data_i[8 + `CRR_PROG_PERM] | prog[`CRR_PROG_PERM];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rd           <= '0;
      prog         <= `CRR_PROG_RESET;
      wr_done_o    <= 1'b0;
      wr_refused_o <= 1'b0;
    end
    else
    begin
      rd           <= next_rd;
      prog         <= next_prog;
      wr_done_o    <= next_wr_done;
      wr_refused_o <= next_wr_refused;
    end
  end

  assign rd_valid_o = rd.valid;
  assign rd_data_o  = rd.data;

  // =====================================================
  // Address translation and power-up
  // =====================================================
  crr_addr_type addr;
  crr_addr_type next_addr;
  logic [11:0]  pwr_cnt;
  logic [11:0]  next_pwr_cnt;
  logic         next_ready;

  always_comb
  begin
    next_addr.valid = addr_req_i;
    if (sector_mode_o)
      next_addr.byte_addr = {addr_arg_i, `CRR_SECTOR_PAD};
    else
      next_addr.byte_addr = {`CRR_SECTOR_PAD, addr_arg_i};
    next_pwr_cnt = pwr_cnt;
    next_ready   = ready_o;
    if (pwr_cnt == `CRR_POWERUP_CYC)
      next_ready = 1'b1;
    else
      next_pwr_cnt = pwr_cnt + 12'h001;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      addr          <= '0;
      pwr_cnt       <= 12'h000;
      ready_o       <= 1'b0;
      sector_mode_o <= SECTOR_MODE;
    end
    else
    begin
      addr          <= next_addr;
      pwr_cnt       <= next_pwr_cnt;
      ready_o       <= next_ready;
      sector_mode_o <= SECTOR_MODE;
    end
  end

  assign addr_valid_o = addr.valid;
  assign byte_addr_o  = addr.byte_addr;

  // =====================================================
  // Clock-dependent access timer
  // =====================================================
  logic           bclk_s1;
  logic           bclk_s2;
  logic           bclk_s3;
  logic           bus_edge;
  crr_tstate_type tstate;
  crr_tstate_type next_tstate;
  logic [15:0]    tcnt;
  logic [15:0]    next_tcnt;
  logic [15:0]    target;
  logic           next_expired;

  assign bus_edge = bclk_s2 && !bclk_s3;
  assign target   = {8'h00, `CRR_ACC_CLOCKS} * `CRR_CLOCK_UNIT;

  // A halted bus clock simply stalls the count; a new request restarts it
  always_comb
  begin
    next_tstate  = tstate;
    next_tcnt    = tcnt;
    next_expired = 1'b0;
    unique case (tstate)
      CRR_T_IDLE:
      begin
        if (addr_req_i)
        begin
          next_tstate = CRR_T_RUN;
          next_tcnt   = 16'h0000;
        end
      end
      CRR_T_RUN:
      begin
        if (addr_req_i)
          next_tcnt = 16'h0000;
        else if (bus_edge && (tcnt == target - 16'h0001))
        begin
          next_tstate  = CRR_T_IDLE;
          next_expired = 1'b1;
        end
        else if (bus_edge)
          next_tcnt = tcnt + 16'h0001;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      bclk_s1          <= 1'b0;
      bclk_s2          <= 1'b0;
      bclk_s3          <= 1'b0;
      tstate           <= CRR_T_IDLE;
      tcnt             <= 16'h0000;
      access_expired_o <= 1'b0;
    end
    else
    begin
      bclk_s1          <= bus_clk_i;
      bclk_s2          <= bclk_s1;
      bclk_s3          <= bclk_s2;
      tstate           <= next_tstate;
      tcnt             <= next_tcnt;
      access_expired_o <= next_expired;
    end
  end

  // =====================================================
  // Assertions
  // =====================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_ident_rd;
    rd_req_i && (rd_sel_i == CRR_SEL_IDENT);
  endsequence
  sequence s_spec_rd;
    rd_req_i && (rd_sel_i == CRR_SEL_SPEC);
  endsequence
  sequence s_opc_rd;
    rd_req_i && (rd_sel_i == CRR_SEL_OPCOND);
  endsequence

  property p_mode_bits;
    s_opc_rd |=> rd_valid_o && (rd_data_o[30:29] == (SECTOR_MODE ? 2'b10 : 2'b00));
  endproperty
  a_mode_bits: assert property (p_mode_bits) else $error("access mode bits wrong");

  property p_sector_scale;
    addr_req_i && SECTOR_MODE |=> addr_valid_o && (byte_addr_o == {$past(addr_arg_i), 9'h000});
  endproperty
  a_sector_scale: assert property (p_sector_scale) else $error("sector scaling wrong");

  property p_byte_addr;
    addr_req_i && !SECTOR_MODE |=> addr_valid_o && (byte_addr_o == {9'h000, $past(addr_arg_i)});
  endproperty
  a_byte_addr: assert property (p_byte_addr) else $error("byte address wrong");

  property p_ident_layout;
    s_ident_rd |=> rd_valid_o && (rd_data_o[127:120] == MAKER_CODE)
      && (rd_data_o[113:112] == 2'h1) && (rd_data_o[111:104] == APP_CODE)
      && (rd_data_o[103:56] == PRODUCT_NAME) && (rd_data_o[47:16] == SERIAL);
  endproperty
  a_ident_layout: assert property (p_ident_layout) else $error("identity layout wrong");

  property p_ident_crc;
    s_ident_rd |=> (rd_data_o[7:1] == crr_crc7(rd_data_o[127:8])) && rd_data_o[0];
  endproperty
  a_ident_crc: assert property (p_ident_crc) else $error("identity checksum wrong");

  property p_spec_timing;
    s_spec_rd |=> (rd_data_o[119:112] == 8'h27) && (rd_data_o[111:104] == 8'h01)
      && (rd_data_o[103:96] == 8'h32);
  endproperty
  a_spec_timing: assert property (p_spec_timing) else $error("timing fields wrong");

  property p_spec_blocks;
    s_spec_rd |=> (rd_data_o[83:80] == 4'h9) && !rd_data_o[79] && !rd_data_o[76]
      && (rd_data_o[25:22] == 4'h9) && !rd_data_o[21];
  endproperty
  a_spec_blocks: assert property (p_spec_blocks) else $error("block fields wrong");

  property p_spec_groups;
    s_spec_rd |=> (rd_data_o[46:42] == 5'h1f) && (rd_data_o[41:37] == 5'h1f)
      && (rd_data_o[36:32] == 5'h0f) && rd_data_o[31]
      && (rd_data_o[7:1] == crr_crc7(rd_data_o[127:8])) && rd_data_o[0];
  endproperty
  a_spec_groups: assert property (p_spec_groups) else $error("group or checksum wrong");

  property p_refused_keeps;
    wr_req_i && (wr_sel_i != CRR_SEL_SPEC) |=> wr_refused_o && wr_done_o && (prog == $past(prog));
  endproperty
  a_refused_keeps: assert property (p_refused_keeps) else $error("refused write changed data");

  property p_expire_count;
    access_expired_o |-> ($past(tstate) == CRR_T_RUN) && $past(bus_edge)
      && ($past(tcnt) == 16'h0063);
  endproperty
  a_expire_count: assert property (p_expire_count) else $error("access timer count wrong");
endmodule

// ===== bench/crr_host_model.sv
// Host side of the readout block: the bus clock that the host supplies.
// Assumes the bench opens and closes frames with run_i; the pin idles low between them.
`timescale 1ns/1ps
module crr_host_model #(
  parameter int HALF_NS = 160
) (
  input  wire logic run_i,
  output logic      bus_clk_o
);
  // ==========================================================
  // Bus clock
  // Stands still outside frames, so the access timer must stall
  // Odd start offset keeps pin edges off the sampling clock edges
  always
  begin
    if (!run_i)
    begin
      bus_clk_o = 1'b0;
      @(posedge run_i);
      #13;
    end
    #HALF_NS bus_clk_o = 1'b1;
    #HALF_NS bus_clk_o = 1'b0;
  end
endmodule

// ===== bench/crr_card_register_readout_tb_top.sv
// Self-checking bench for the card register readout block.
// Assumes the host model drives the bus clock pin; a second instance runs in byte mode.
`timescale 1ns/1ps
module crr_card_register_readout_tb_top;
  import crr_pkg::*;
  logic         clk_i    = 1'b0;
  logic         nrst_i   = 1'b0;
  logic         rd_req   = 1'b0;
  logic         wr_req   = 1'b0;
  logic         addr_req = 1'b0;
  logic         run      = 1'b0;
  crr_sel_type  rd_sel   = CRR_SEL_OPCOND;
  crr_sel_type  wr_sel   = CRR_SEL_SPEC;
  logic [127:0] wr_data  = '0;
  logic [31:0]  addr_arg = '0;
  logic         bus_clk;
  logic         rd_valid;
  logic         wr_done;
  logic         wr_ref;
  logic         addr_valid;
  logic         sector;
  logic         ready;
  logic         expired;
  logic         sector_b;
  logic [127:0] rd_data;
  logic [127:0] rd_data_b;
  logic [40:0]  byte_addr;
  logic [40:0]  byte_addr_b;
  logic [127:0] ident;
  int           err_total   = 0;
  int           checks_done = 0;
  int           cyc         = 0;
  int           n;

  always #20 clk_i = ~clk_i;

  crr_host_model u_host (.run_i(run), .bus_clk_o(bus_clk));

  crr_card_register_readout u_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .bus_clk_i(bus_clk),
    .rd_req_i(rd_req), .rd_sel_i(rd_sel), .wr_req_i(wr_req), .wr_sel_i(wr_sel),
    .wr_data_i(wr_data), .addr_req_i(addr_req), .addr_arg_i(addr_arg),
    .rd_valid_o(rd_valid), .rd_data_o(rd_data), .wr_done_o(wr_done),
    .wr_refused_o(wr_ref), .addr_valid_o(addr_valid), .byte_addr_o(byte_addr),
    .sector_mode_o(sector), .ready_o(ready), .access_expired_o(expired));

  // Exactly 2 GB: the largest size that keeps byte addressing
  crr_card_register_readout #(.DEV_BYTES(64'h0000_0000_8000_0000)) u_dut_b (
    .clk_i(clk_i), .nrst_i(nrst_i), .bus_clk_i(bus_clk),
    .rd_req_i(rd_req), .rd_sel_i(rd_sel), .wr_req_i(wr_req), .wr_sel_i(wr_sel),
    .wr_data_i(wr_data), .addr_req_i(addr_req), .addr_arg_i(addr_arg),
    .rd_valid_o(), .rd_data_o(rd_data_b), .wr_done_o(), .wr_refused_o(),
    .addr_valid_o(), .byte_addr_o(byte_addr_b), .sector_mode_o(sector_b),
    .ready_o(), .access_expired_o());

  // ==========================================================
  // Compare and report
  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [127:0] exp, input logic [127:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // Expected words
  function automatic logic [127:0] seal(input logic [127:0] w);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = 127; i >= 8; i--)
    begin
      fb = w[i] ^ c[6];
      c = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
    end
    return {w[127:8], c, 1'b1};
  endfunction

  function automatic logic [127:0] opc(input logic rdy, input logic [1:0] mode);
    return {96'h0, rdy, mode, 5'h00, 9'h1ff, 7'h00, 1'b1, 7'h00};
  endfunction

  function automatic logic [127:0] spec_word(input logic [7:0] prog);
    crr_spec_type s;
    s = '0;
    s.structure = 2'h3;
    s.spec_version = 4'h4;
    s.access_time_fixed = 8'h27;
    s.access_time_clocks = 8'h01;
    s.transfer_speed = 8'h32;
    s.command_classes = 12'h0f5;
    s.read_block_length = 4'h9;
    s.device_size = 12'hfff;
    s.currents = 12'hfff;
    s.size_mult = 3'h7;
    s.erase_group_size = 5'h1f;
    s.erase_group_multiplier = 5'h1f;
    s.protect_group_size = 5'h0f;
    s.protect_group_enable = 1'b1;
    s.write_speed_factor = 3'h2;
    s.write_block_length = 4'h9;
    s.prog_bits = prog;
    return seal(s);
  endfunction

  // ==========================================================
  // Access tasks
  task automatic do_read(input crr_sel_type sel, input logic [127:0] exp);
    @(negedge clk_i);
    rd_req = 1'b1;
    rd_sel = sel;
    @(negedge clk_i);
    rd_req = 1'b0;
    chk_bit("rd_valid", 1'b1, rd_valid);
    chk_word("rd_data", exp, rd_data);
  endtask

  task automatic do_write(input crr_sel_type sel, input logic [127:0] d, input logic refused);
    @(negedge clk_i);
    wr_req = 1'b1;
    wr_sel = sel;
    wr_data = d;
    @(negedge clk_i);
    wr_req = 1'b0;
    chk_bit("wr_done", 1'b1, wr_done);
    chk_bit("wr_refused", refused, wr_ref);
  endtask

  task automatic do_addr(input logic [31:0] arg);
    @(negedge clk_i);
    addr_req = 1'b1;
    addr_arg = arg;
    @(negedge clk_i);
    addr_req = 1'b0;
    chk_bit("addr_valid", 1'b1, addr_valid);
    chk_word("byte_addr", {87'h0, arg, 9'h000}, {87'h0, byte_addr});
    chk_word("byte_addr_b", {96'h0, arg}, {87'h0, byte_addr_b});
  endtask

  // ==========================================================
  // Hang guard, about three times the expected run
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  initial
  begin
    ident = seal({8'h5a, 6'h00, 2'h1, 8'ha5, 48'h4142_4344_4546, 8'h10, 32'h1, 8'h11, 8'h00});
    repeat (5) @(negedge clk_i);
    nrst_i = 1'b1;
    chk_bit("ready", 1'b0, ready);
    chk_bit("sector_mode", 1'b1, sector);
    chk_bit("sector_mode_b", 1'b0, sector_b);
    do_read(CRR_SEL_OPCOND, opc(1'b0, 2'h2));
    chk_word("opcond_b", opc(1'b0, 2'h0), rd_data_b);
    n = 0;
    while (ready !== 1'b1 && n < 1100)
    begin
      @(negedge clk_i);
      n++;
    end
    chk_bit("ready_time", 1'b1, n >= 995 && n <= 1000);
    do_read(CRR_SEL_OPCOND, opc(1'b1, 2'h2));
    do_read(crr_sel_type'(2'h3), opc(1'b1, 2'h2));
    $display("test opcond done");
    do_read(CRR_SEL_IDENT, ident);
    do_read(CRR_SEL_SPEC, spec_word(8'h40));
    $display("test registers done");
    // Refused writes leave both registers alone
    do_write(CRR_SEL_IDENT, ~ident, 1'b1);
    do_read(CRR_SEL_IDENT, ident);
    do_write(CRR_SEL_SPEC, spec_word(8'h40) ^ (128'h1 << 104), 1'b1);
    do_write(CRR_SEL_SPEC, spec_word(8'h40) | (128'h1 << 79), 1'b1);
    do_read(CRR_SEL_SPEC, spec_word(8'h40));
    // Copy and permanent protect only ever set
    do_write(CRR_SEL_SPEC, spec_word(8'h20), 1'b0);
    do_read(CRR_SEL_SPEC, spec_word(8'h60));
    do_write(CRR_SEL_SPEC, spec_word(8'h00), 1'b0);
    do_read(CRR_SEL_SPEC, spec_word(8'h60));
    $display("test writes done");
    do_addr(32'h0000_0001);
    do_addr(32'hffff_ffff);
    $display("test address done");
    do_addr(32'h0000_0010);
    run = 1'b1;
    n = 0;
    while (expired !== 1'b1 && n < 1200)
    begin
      @(negedge clk_i);
      n++;
    end
    run = 1'b0;
    chk_bit("access_time", 1'b1, n > 790 && n < 812);
    $display("test access timer done");
    tally_and_finish();
  end
endmodule
